/* common/sppic_pkg.sv */
// constants for the synced pwm interleave control core
package sppic_pkg;
   // clock and sync line timing
   localparam int CLK_FREQ_KHZ = 250000; // core clock rate
   localparam int SYNC_FREQ_KHZ = 500; // sync line clock from the power manager
   localparam int SYNC_PERIOD_CYC = CLK_FREQ_KHZ / SYNC_FREQ_KHZ; // nominal sync period in cycles
   localparam logic [11:0] LOCK_TOL_CYC = 12'h0008; // period match window for lock
   localparam logic [2:0] LOCK_COUNT = 3'h4; // matching periods needed to lock
   localparam logic [11:0] LOSS_CYC = 12'(2 * SYNC_PERIOD_CYC); // no falling edge this long drops lock
   // register offsets
   localparam logic [7:0] ADDR_INTERLEAVE = 8'h04;
   localparam logic [7:0] ADDR_DUTY_LIMIT = 8'h09;
   localparam logic [7:0] ADDR_PROP = 8'h0A;
   localparam logic [7:0] ADDR_INTEG = 8'h0B;
   localparam logic [7:0] ADDR_DERIV = 8'h0C;
   localparam logic [7:0] ADDR_ROLLOFF = 8'h0D;
   localparam logic [7:0] ADDR_SYSTEM_IDENTIFICATION = 8'h0E;
   localparam logic [7:0] ADDR_CAP_INDEX = 8'h0F;
   localparam logic [7:0] ADDR_CAP_LOW = 8'h10;
   localparam logic [7:0] ADDR_CAP_HIGH = 8'h11;
   // field positions
   localparam int PHASE_MSB = 7;
   localparam int PHASE_LSB = 6;
   localparam int RATE_BIT = 5;
   localparam int INTERLEAVE_MSB = 3;
   localparam int DUTY_MSB = 7;
   localparam int DUTY_LSB = 2;
   localparam int SYSTEM_IDENTIFICATION_RUN_BIT = 0;
   localparam int SYSTEM_IDENTIFICATION_DONE_BIT = 1;
   localparam int SYSTEM_IDENTIFICATION_AMP_LSB = 4;
   // reset values
   localparam logic [3:0] INTERLEAVE_RESET = 4'h0;
   localparam logic RATE_RESET = 1'b0;
   localparam logic [5:0] DUTY_LIMIT_RESET = 6'h3A;
   localparam logic [7:0] COEFF_RESET = 8'h00;
   localparam logic [6:0] PRBS_SEED = 7'h7F;
   // lock state
   typedef enum logic [1:0] {SPPIC_HUNT, SPPIC_TRACK, SPPIC_LOCKED} sppic_lock_t;
endpackage : sppic_pkg

/* verilog/sppic_capture_mem.sv */
// response capture memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module sppic_capture_mem #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 64,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clock, // core clock
   input wire logic wr_en, // write strobe
   input wire logic [AW-1:0] wr_addr, // write index
   input wire logic [WIDTH-1:0] wr_data, // write word
   input wire logic [AW-1:0] rd_addr, // read index
   output logic [WIDTH-1:0] rd_data // read word, one cycle late
);
   logic [WIDTH-1:0] mem [DEPTH];
   // write port and registered read port
   always_ff @(posedge clock)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : sppic_capture_mem
`default_nettype wire

/* verilog/sppic_core.sv */
// sync-locked pwm timing, interleave, duty limit, pid and system identification
`timescale 1ns/1ns
`default_nettype none
module sppic_core #(
   parameter int CAP_DEPTH = 64,
   parameter int CAP_AW = $clog2(CAP_DEPTH)
) (
   input wire logic clock, // core clock
   input wire logic rst, // async reset, active high
   input wire logic sync_line, // sync clock pin
   input wire logic [1:0] phase_strap, // phase count strap pins
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   input wire logic reg_write, // write strobe
   input wire logic reg_read, // read strobe
   output logic [7:0] reg_rdata, // read data
   output logic reg_rvalid, // read data valid pulse
   input wire logic [7:0] nominal_duty, // nominal ratio in 1/256
   input wire logic signed [11:0] err_sample, // regulation error sample
   input wire logic err_valid, // error sample strobe
   input wire logic [11:0] vout_sample, // output voltage sample
   output logic [3:0] pwm_out, // pwm outputs 0 to 3
   output logic locked // sync lock indication
);
   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] sync_ff_reg;
   logic sync_prev_reg;
   logic [1:0] strap_ff1_reg, strap_ff2_reg;
   logic strap_done_reg;
   logic [1:0] phase_reg;
   logic sync_fall;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sync_ff_reg <= 2'h0;
         sync_prev_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         phase_reg <= 2'h0;
      end
      else
      begin
         sync_ff_reg <= {sync_ff_reg[0], sync_line};
         sync_prev_reg <= sync_ff_reg[1];
         strap_done_reg <= 1'b1;
         if (!strap_done_reg)
         begin
            phase_reg <= strap_ff2_reg;
         end
      end
   end
   assign sync_fall = sync_prev_reg && !sync_ff_reg[1];
   // strap synchroniser keeps running through reset so the pins are settled at release
   always_ff @(posedge clock)
   begin
      strap_ff1_reg <= phase_strap;
      strap_ff2_reg <= strap_ff1_reg;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file
   logic [3:0] ilv_reg, ilv_next;
   logic rate_reg, rate_next;
   logic [5:0] dlim_reg, dlim_next;
   logic [7:0] cp_reg, cp_next, ci_reg, ci_next, cd_reg, cd_next, b1_reg, b1_next;
   logic run_reg, run_next;
   logic [3:0] amp_reg, amp_next;
   logic [CAP_AW-1:0] cidx_reg, cidx_next;
   logic [7:0] rdata_next;
   logic cap_done_reg;
   logic [11:0] cap_rd_data;
   always_comb
   begin
      ilv_next = ilv_reg;
      rate_next = rate_reg;
      dlim_next = dlim_reg;
      cp_next = cp_reg;
      ci_next = ci_reg;
      cd_next = cd_reg;
      b1_next = b1_reg;
      run_next = run_reg;
      amp_next = amp_reg;
      cidx_next = cidx_reg;
      if (reg_write)
      begin
         case (reg_addr)
            sppic_pkg::ADDR_INTERLEAVE:
            begin
               ilv_next = reg_wdata[sppic_pkg::INTERLEAVE_MSB:0];
               rate_next = reg_wdata[sppic_pkg::RATE_BIT];
            end
            sppic_pkg::ADDR_DUTY_LIMIT: dlim_next = reg_wdata[sppic_pkg::DUTY_MSB:sppic_pkg::DUTY_LSB];
            sppic_pkg::ADDR_PROP: cp_next = reg_wdata;
            sppic_pkg::ADDR_INTEG: ci_next = reg_wdata;
            sppic_pkg::ADDR_DERIV: cd_next = reg_wdata;
            sppic_pkg::ADDR_ROLLOFF: b1_next = reg_wdata;
            sppic_pkg::ADDR_SYSTEM_IDENTIFICATION:
            begin
               run_next = reg_wdata[sppic_pkg::SYSTEM_IDENTIFICATION_RUN_BIT];
               amp_next = reg_wdata[7:sppic_pkg::SYSTEM_IDENTIFICATION_AMP_LSB];
            end
            sppic_pkg::ADDR_CAP_INDEX: cidx_next = reg_wdata[CAP_AW-1:0];
            default: ;
         endcase
      end
      case (reg_addr)
         sppic_pkg::ADDR_INTERLEAVE: rdata_next = {phase_reg, rate_reg, 1'b0, ilv_reg};
         sppic_pkg::ADDR_DUTY_LIMIT: rdata_next = {dlim_reg, 2'h0};
         sppic_pkg::ADDR_PROP: rdata_next = cp_reg;
         sppic_pkg::ADDR_INTEG: rdata_next = ci_reg;
         sppic_pkg::ADDR_DERIV: rdata_next = cd_reg;
         sppic_pkg::ADDR_ROLLOFF: rdata_next = b1_reg;
         sppic_pkg::ADDR_SYSTEM_IDENTIFICATION: rdata_next = {amp_reg, 2'h0, cap_done_reg, run_reg};
         sppic_pkg::ADDR_CAP_INDEX: rdata_next = 8'(cidx_reg);
         sppic_pkg::ADDR_CAP_LOW: rdata_next = cap_rd_data[7:0];
         sppic_pkg::ADDR_CAP_HIGH: rdata_next = {4'h0, cap_rd_data[11:8]};
         default: rdata_next = 8'h00;
      endcase
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ilv_reg <= sppic_pkg::INTERLEAVE_RESET;
         rate_reg <= sppic_pkg::RATE_RESET;
         dlim_reg <= sppic_pkg::DUTY_LIMIT_RESET;
         cp_reg <= sppic_pkg::COEFF_RESET;
         ci_reg <= sppic_pkg::COEFF_RESET;
         cd_reg <= sppic_pkg::COEFF_RESET;
         b1_reg <= sppic_pkg::COEFF_RESET;
         run_reg <= 1'b0;
         amp_reg <= 4'h0;
         cidx_reg <= '0;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         ilv_reg <= ilv_next;
         rate_reg <= rate_next;
         dlim_reg <= dlim_next;
         cp_reg <= cp_next;
         ci_reg <= ci_next;
         cd_reg <= cd_next;
         b1_reg <= b1_next;
         run_reg <= run_next;
         amp_reg <= amp_next;
         cidx_reg <= cidx_next;
         reg_rdata <= reg_read ? rdata_next : reg_rdata;
         reg_rvalid <= reg_read;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sync period lock loop
   sppic_pkg::sppic_lock_t lock_reg, lock_next;
   logic [11:0] since_reg, since_next, period_reg, period_next;
   logic [2:0] match_reg, match_next;
   logic [11:0] diff_abs;
   always_comb
   begin
      lock_next = lock_reg;
      period_next = period_reg;
      match_next = match_reg;
      since_next = (since_reg == 12'hFFF) ? since_reg : since_reg + 12'h001;
      diff_abs = (since_reg > period_reg) ? since_reg - period_reg : period_reg - since_reg;
      if (sync_fall)
      begin
         since_next = 12'h001;
         case (lock_reg)
            sppic_pkg::SPPIC_HUNT:
            begin
               lock_next = sppic_pkg::SPPIC_TRACK;
               match_next = 3'h0;
            end
            sppic_pkg::SPPIC_TRACK, sppic_pkg::SPPIC_LOCKED:
            begin
               if (diff_abs <= sppic_pkg::LOCK_TOL_CYC)
               begin
                  match_next = (match_reg == sppic_pkg::LOCK_COUNT) ? match_reg : match_reg + 3'h1;
                  if (match_reg + 3'h1 >= sppic_pkg::LOCK_COUNT)
                  begin
                     lock_next = sppic_pkg::SPPIC_LOCKED;
                  end
               end
               else
               begin
                  match_next = 3'h0;
                  lock_next = sppic_pkg::SPPIC_TRACK;
               end
               period_next = since_reg;
            end
            default: lock_next = sppic_pkg::SPPIC_HUNT;
         endcase
      end
      else if (since_reg >= sppic_pkg::LOSS_CYC)
      begin
         lock_next = sppic_pkg::SPPIC_HUNT;
      end
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lock_reg <= sppic_pkg::SPPIC_HUNT;
         since_reg <= 12'h000;
         period_reg <= 12'(sppic_pkg::SYNC_PERIOD_CYC);
         match_reg <= 3'h0;
         locked <= 1'b0;
      end
      else
      begin
         lock_reg <= lock_next;
         since_reg <= since_next;
         period_reg <= period_next;
         match_reg <= match_next;
         locked <= (lock_next == sppic_pkg::SPPIC_LOCKED);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pid compensation
   logic signed [19:0] integ_reg, integ_next;
   logic signed [11:0] eprev_reg, eprev_next;
   logic signed [15:0] dflt_reg, dflt_next;
   logic signed [13:0] pid_reg, pid_next;
   logic signed [24:0] dstep, pid_sum;
   always_comb
   begin
      integ_next = integ_reg;
      eprev_next = eprev_reg;
      dflt_next = dflt_reg;
      dstep = ((25'(err_sample - eprev_reg) - 25'(dflt_reg)) * $signed({1'b0, b1_reg})) >>> 8;
      pid_sum = (25'(err_sample) * $signed({1'b0, cp_reg}) + 25'(integ_reg >>> 8) * $signed({1'b0, ci_reg})
         + 25'(dflt_reg) * $signed({1'b0, cd_reg})) >>> 8;
      pid_next = pid_reg;
      if (err_valid)
      begin
         integ_next = integ_reg + 20'(err_sample);
         eprev_next = err_sample;
         dflt_next = dflt_reg + 16'(dstep);
         pid_next = 14'(pid_sum);
      end
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         integ_reg <= '0;
         eprev_reg <= '0;
         dflt_reg <= '0;
         pid_reg <= '0;
      end
      else
      begin
         integ_reg <= integ_next;
         eprev_reg <= eprev_next;
         dflt_reg <= dflt_next;
         pid_reg <= pid_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // cycle scheduling, pwm and identification
   logic [11:0] phase_cnt_reg, phase_cnt_next, pwm_cnt_reg, pwm_cnt_next;
   logic [11:0] duty_reg, duty_next, cyc_len_reg, cyc_len_next, delay_reg, delay_next;
   logic rate_act_reg, rate_act_next;
   logic [6:0] prbs_reg, prbs_next;
   logic [CAP_AW-1:0] cap_wr_reg, cap_wr_next;
   logic cap_done_next, cap_we;
   logic [11:0] half, delay2, cyc_len, lim_ticks, nom_ticks;
   logic signed [15:0] duty_sum;
   logic start;
   always_comb
   begin
      half = period_reg >> 1;
      delay2 = (delay_reg >= half) ? delay_reg - half : delay_reg + half;
      phase_cnt_next = sync_fall ? 12'h000 : phase_cnt_reg + 12'h001;
      start = (lock_reg == sppic_pkg::SPPIC_LOCKED)
         && (phase_cnt_reg == delay_reg || (rate_act_reg && phase_cnt_reg == delay2));
      cyc_len = rate_reg ? half : period_reg;
      lim_ticks = 12'((20'(cyc_len) * 20'(dlim_reg)) >> 6);
      nom_ticks = 12'((20'(cyc_len) * 20'(nominal_duty)) >> 8);
      duty_sum = 16'(nom_ticks) + 16'(pid_reg);
      if (run_reg)
      begin
         duty_sum = prbs_reg[0] ? duty_sum + 16'(amp_reg) : duty_sum - 16'(amp_reg);
      end
      rate_act_next = rate_act_reg;
      delay_next = delay_reg;
      cyc_len_next = cyc_len_reg;
      duty_next = duty_reg;
      prbs_next = prbs_reg;
      pwm_cnt_next = (pwm_cnt_reg < cyc_len_reg) ? pwm_cnt_reg + 12'h001 : pwm_cnt_reg;
      cap_wr_next = cap_wr_reg;
      cap_done_next = cap_done_reg;
      cap_we = 1'b0;
      if (!run_reg)
      begin
         cap_wr_next = '0;
         cap_done_next = 1'b0;
      end
      if (start)
      begin
         rate_act_next = rate_reg;
         cyc_len_next = cyc_len;
         delay_next = 12'((20'(period_reg) * 20'(ilv_reg)) >> 4);
         duty_next = (duty_sum < 16'sh0000) ? 12'h000 : (duty_sum > $signed(16'(lim_ticks))) ? lim_ticks : 12'(duty_sum);
         pwm_cnt_next = 12'h000;
         if (run_reg && !cap_done_reg)
         begin
            prbs_next = {prbs_reg[5:0], prbs_reg[6] ^ prbs_reg[5]};
            cap_we = 1'b1;
            cap_wr_next = cap_wr_reg + 1'b1;
            cap_done_next = (cap_wr_reg == CAP_AW'(CAP_DEPTH - 1));
         end
      end
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         phase_cnt_reg <= 12'h000;
         pwm_cnt_reg <= 12'h000;
         duty_reg <= 12'h000;
         cyc_len_reg <= 12'h000;
         delay_reg <= 12'h000;
         rate_act_reg <= sppic_pkg::RATE_RESET;
         prbs_reg <= sppic_pkg::PRBS_SEED;
         cap_wr_reg <= '0;
         cap_done_reg <= 1'b0;
      end
      else
      begin
         phase_cnt_reg <= phase_cnt_next;
         pwm_cnt_reg <= pwm_cnt_next;
         duty_reg <= duty_next;
         cyc_len_reg <= cyc_len_next;
         delay_reg <= delay_next;
         rate_act_reg <= rate_act_next;
         prbs_reg <= prbs_next;
         cap_wr_reg <= cap_wr_next;
         cap_done_reg <= cap_done_next;
      end
   end

   // per-output enable from the phase count, high while counting below duty
   for (genvar k = 0; k < 4; k++)
   begin : g_out
      logic en;
      assign en = (k == 0) || (k == 2 && phase_reg != 2'h0) || (k == 1 && phase_reg[1]) || (k == 3 && phase_reg == 2'h3);
      always_ff @(posedge clock or posedge rst)
      begin
         if (rst)
         begin
            pwm_out[k] <= 1'b0;
         end
         else
         begin
            pwm_out[k] <= en && (lock_reg == sppic_pkg::SPPIC_LOCKED) && (pwm_cnt_next < duty_next);
         end
      end
   end

   // identification response store
   sppic_capture_mem #(.WIDTH(12), .DEPTH(CAP_DEPTH)) u_cap (
      .clock(clock),
      .wr_en(cap_we),
      .wr_addr(cap_wr_reg),
      .wr_data(vout_sample),
      .rd_addr(cidx_reg),
      .rd_data(cap_rd_data)
   );
endmodule : sppic_core
`default_nettype wire

/* testbench/sppic_core_assertions.sv */
// concurrent checks on the ports of the sync-locked pwm core
`timescale 1ns/1ns
`default_nettype none
module sppic_core_assertions (
   input wire logic clock, // core clock
   input wire logic rst, // async reset
   input wire logic sync_line, // sync pin
   input wire logic [1:0] phase_strap, // phase strap pins
   input wire logic [7:0] reg_addr, // register address
   input wire logic reg_read, // read strobe
   input wire logic [7:0] reg_rdata, // read data
   input wire logic reg_rvalid, // read valid pulse
   input wire logic [3:0] pwm_out, // pwm outputs
   input wire logic locked // lock flag
);
   logic sync_d_reg, sync_d_next;
   logic [11:0] still_reg, still_next;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   //////////////////////////////////////////////////////////////
   // cycles since the sync pin last moved, saturating
   always_comb
   begin
      sync_d_next = sync_line;
      still_next = (sync_line != sync_d_reg) ? 12'h000 : (still_reg == 12'hFFF) ? still_reg : still_reg + 12'h001;
   end
   // registers of the quiet-line counter
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sync_d_reg <= 1'b1;
         still_reg <= 12'h000;
      end
      else
      begin
         sync_d_reg <= sync_d_next;
         still_reg <= still_next;
      end
   end
   //////////////////////////////////////////////////////////////
   a_read_answer: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
   a_no_stray_valid: assert property (!reg_read |=> !reg_rvalid) else $error("stray read valid");
   a_unmapped_zero: assert property (reg_read && reg_addr > 8'h11 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_gap_bit_zero: assert property (reg_read && reg_addr == sppic_pkg::ADDR_INTERLEAVE |=> !reg_rdata[4])
      else $error("interleave bit 4 set");
   a_phase_report: assert property (reg_read && reg_addr == sppic_pkg::ADDR_INTERLEAVE
      |=> reg_rdata[7:6] == phase_strap) else $error("phase count wrong");
   a_limit_low_zero: assert property (reg_read && reg_addr == sppic_pkg::ADDR_DUTY_LIMIT
      |=> reg_rdata[1:0] == 2'h0) else $error("limit low bits set");
   a_idle_unlocked: assert property (!locked && !$past(locked) |-> pwm_out == 4'h0)
      else $error("pwm while unlocked");
   a_unused_output: assert property (phase_strap != 2'h3 |-> !pwm_out[3]) else $error("output 3 active");
   a_lock_dropped: assert property (still_reg >= 12'h44C |-> !locked) else $error("lock kept without sync");
   // main scenarios reached
   c_locked: cover property ($rose(locked));
   c_read: cover property (reg_rvalid);
   c_pwm_output_zero: cover property ($rose(pwm_out[0]));
   c_pwm2: cover property ($rose(pwm_out[2]));
endmodule : sppic_core_assertions
bind sppic_core sppic_core_assertions sppic_core_assertions_i (.clock(clock), .rst(rst), .sync_line(sync_line),
   .phase_strap(phase_strap), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .pwm_out(pwm_out), .locked(locked));
`default_nettype wire

/* testbench/sppic_power_manager.sv */
// behavioural power manager driving the shared sync line
`timescale 1ns/1ns
`default_nettype none
module sppic_power_manager #(
   parameter int HALF_NS = 1000
) (
   input wire logic run, // sync clock runs while high
   output logic sync_line // sync clock to the units
);
   initial sync_line = 1'b1;
   // 500 kHz clock whose falling edge is the reference; parks high when stopped
   always
   begin
      #(HALF_NS) sync_line = run ? ~sync_line : 1'b1;
   end
endmodule : sppic_power_manager
`default_nettype wire

/* testbench/tb_synced_pwm_interleave_control.sv */
// self-checking bench for the sync-locked pwm core
`timescale 1ns/1ns
`default_nettype none
module tb_synced_pwm_interleave_control;
   logic clock, rst, sync_run, reg_write, reg_read, err_valid, reg_rvalid, locked, sync_line, prev;
   logic [1:0] phase_strap;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, nominal_duty, d;
   logic signed [11:0] err_sample;
   logic [11:0] vout_sample;
   logic [3:0] pwm_out, used_outputs;
   int num_errors = 0;
   int cmp_count = 0;
   int lag0, lag, wid, n;
   sppic_core #(.CAP_DEPTH(8)) sppic_core_i (.clock(clock), .rst(rst), .sync_line(sync_line),
      .phase_strap(phase_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .nominal_duty(nominal_duty),
      .err_sample(err_sample), .err_valid(err_valid), .vout_sample(vout_sample), .pwm_out(pwm_out),
      .locked(locked));
   sppic_power_manager sppic_power_manager_i (.run(sync_run), .sync_line(sync_line));
   //////////////////////////////////////////////////////////////
   // core clock, 4 ns
   always #2 clock = ~clock;
   // remembers every output that ever pulsed
   always @(posedge clock) used_outputs <= used_outputs | pwm_out;
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // one write, taken at the edge after it is raised
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   // one read; data and valid land at the edge that takes it
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      check("read valid", 12'(reg_rvalid), 12'h001);
   endtask : rd
   // cycles from a sync fall to the pulse on output 0, then its width
   task automatic pulse();
      @(negedge sync_line);
      lag = 0;
      while (pwm_out[0] !== 1'b1 && lag < 1000)
      begin
         @(posedge clock);
         #1 lag++;
      end
      wid = 0;
      while (pwm_out[0] === 1'b1 && wid < 1000)
      begin
         @(posedge clock);
         #1 wid++;
      end
   endtask : pulse
   task automatic settle();
      repeat (3) @(negedge sync_line);
   endtask : settle
   //////////////////////////////////////////////////////////////
   task automatic test_registers();
      rd(8'h04);
      check("interleave reset", 12'(d), 12'h080);
      rd(8'h09);
      check("limit reset", 12'(d), 12'h0E8);
      wr(8'h04, 8'hFF);
      wr(8'h09, 8'hFF);
      wr(8'h20, 8'h55);
      rd(8'h04);
      check("interleave rw", 12'(d), 12'h0AF);
      rd(8'h09);
      check("limit rw", 12'(d), 12'h0FC);
      rd(8'h20);
      check("unmapped", 12'(d), 12'h000);
      wr(8'h04, 8'h00);
      wr(8'h09, 8'hE8);
   endtask : test_registers
   task automatic test_lock();
      n = 0;
      sync_run <= 1'b1;
      while (locked !== 1'b1 && n < 5000)
      begin
         @(posedge clock);
         #1 n++;
      end
      check("locked", 12'(locked), 12'h001);
      check("lock not early", 12'(n > 1900), 12'h001);
   endtask : test_lock
   task automatic test_duty();
      settle();
      pulse();
      check("duty nominal", 12'(wid), 12'(sppic_pkg::SYNC_PERIOD_CYC * 128 / 256));
      nominal_duty <= 8'hFF;
      settle();
      pulse();
      check("duty reset cap", 12'(wid), 12'(sppic_pkg::SYNC_PERIOD_CYC * 58 / 64));
      wr(8'h09, 8'h80);
      settle();
      pulse();
      check("duty cap", 12'(wid), 12'(sppic_pkg::SYNC_PERIOD_CYC * 32 / 64));
   endtask : test_duty
   task automatic test_interleave();
      nominal_duty <= 8'h40;
      settle();
      pulse();
      lag0 = lag;
      for (int i = 4; i <= 8; i += 4)
      begin
         wr(8'h04, 8'(i));
         settle();
         pulse();
         check("phase lag", 12'(lag - lag0), 12'(sppic_pkg::SYNC_PERIOD_CYC * i / 16));
      end
   endtask : test_interleave
   task automatic test_rate();
      nominal_duty <= 8'h80;
      for (int r = 1; r >= 0; r--)
      begin
         wr(8'h04, r ? 8'h20 : 8'h00);
         settle();
         @(negedge sync_line);
         n = 0;
         prev = pwm_out[0];
         repeat (sppic_pkg::SYNC_PERIOD_CYC)
         begin
            @(posedge clock);
            #1 n += (pwm_out[0] && !prev) ? 1 : 0;
            prev = pwm_out[0];
         end
         check("pulses per sync", 12'(n), 12'(r + 1));
      end
      wr(8'h04, 8'h20);
      settle();
      pulse();
      check("fast width", 12'(wid), 12'(sppic_pkg::SYNC_PERIOD_CYC / 4));
      wr(8'h04, 8'h00);
   endtask : test_rate
   task automatic test_system_identification();
      // compensation is loaded before identification starts
      for (int i = 0; i < 4; i++) wr(8'h0A + 8'(i), 8'h11 * 8'(i + 1));
      for (int i = 0; i < 4; i++)
      begin
         rd(8'h0A + 8'(i));
         check("coefficient", 12'(d), 12'h011 * 12'(i + 1));
      end
      vout_sample <= 12'hABC;
      wr(8'h0E, 8'h01);
      d = 8'h00;
      for (int i = 0; i < 20 && !d[1]; i++)
      begin
         @(negedge sync_line);
         rd(8'h0E);
      end
      check("capture done", 12'(d[1]), 12'h001);
      wr(8'h0F, 8'h03);
      repeat (2) @(posedge clock);
      rd(8'h10);
      check("capture low", 12'(d), 12'h0BC);
      rd(8'h11);
      check("capture high", 12'(d), 12'h00A);
      wr(8'h0E, 8'h00);
   endtask : test_system_identification
   task automatic test_loss();
      n = 0;
      sync_run <= 1'b0;
      while (locked !== 1'b0 && n < 2000)
      begin
         @(posedge clock);
         #1 n++;
      end
      @(posedge clock);
      #1 check("lock lost", 12'(locked), 12'h000);
      check("pwm off", 12'(pwm_out), 12'h000);
      check("outputs used", 12'(used_outputs), 12'h007);
   endtask : test_loss
   //////////////////////////////////////////////////////////////
   // watchdog against a hang
   initial
   begin
      #400000;
      num_errors++;
      tally_and_finish();
   end
   // main sequence
   initial
   begin
      clock = 1'b0;
      rst = 1'b1;
      sync_run = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      err_valid = 1'b0;
      err_sample = 12'sh000;
      vout_sample = 12'h000;
      nominal_duty = 8'h80;
      phase_strap = 2'h2;
      used_outputs = 4'h0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      test_registers();
      test_lock();
      test_duty();
      test_interleave();
      test_rate();
      test_system_identification();
      test_loss();
      tally_and_finish();
   end
endmodule : tb_synced_pwm_interleave_control
`default_nettype wire
